/* smrc_pkg.sv */
package smrc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int STOP_SETTLE_MIN_US = 17;
   localparam int STOP_SETTLE_TYP_US = 34;
   localparam int STOP_SETTLE_MAX_US = 67;
   localparam int STOP_SETTLE_CYC  = STOP_SETTLE_TYP_US * CLK_MHZ;
   localparam int OPT_READ_MIN_US  = 277;
   localparam int OPT_READ_TYP_US  = 544;
   localparam int OPT_READ_MAX_NS  = 1075000;
   localparam int OPT_READ_CYC     = OPT_READ_TYP_US * CLK_MHZ;
   localparam int PIN_LOW_MIN_NS   = 2000;
   localparam int PIN_LOW_MIN_CYC  = (PIN_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W            = 20;
   localparam int OSC_SEL_W        = 3;
   localparam int NUM_IRQ          = 8;
   // Oscillator settling base: cycles at select 0, shifted left by select
   localparam int OSC_SETTLE_BASE_CYC = 256;
   // ----------------------------------------------------------------
   // Reset vector location
   // ----------------------------------------------------------------
   localparam logic [15:0] RESET_VEC_LO = 16'h0000;
   localparam logic [15:0] RESET_VEC_HI = 16'h0001;
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SMRC_RESET,
      SMRC_OPT_READ,
      SMRC_RST_OSC,
      SMRC_RUN,
      SMRC_STOP,
      SMRC_WAKE_OSC,
      SMRC_WAKE_SETTLE
   } smrc_state_type;
endpackage : smrc_pkg

/* smrc_stop_reset.sv */
// Operation
// - Stop only on the stop instruction
// - Pending unmasked request cancels stop immediately
// - Halt 34 us after standby release
// - Add oscillator wait when crystal selected
// - Stop osc, CPU, 16-bit timer, converter
// - 8-bit timer runs only on slow clock
// - Watchdog runs only on unstoppable slow osc
// - Wake only from timer, undervolt, external
// - Vector if enabled, else next instruction
// - Reset releases stop, then settle, reset
// - Hold CPU 544 us reading option byte
// - Four reset sources, same sequencer reset
// - Start from vector at 0000H/0001H
// - Pins high impedance, one pin low (o_reset_low_output_pin is held at 0 instead)
// - Watchdog reset releases itself automatically
// - Comparator resets release when supply good
// - Stop both oscillators during reset
// - Reset pin low keeps reset while low
// - Undervolt reset spares undervolt configuration
// - Cause flags set, held or cleared
`timescale 1ns/1ps
module smrc_stop_reset (
   input  wire logic                         i_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_reset_n_pin,
   input  wire logic                         i_por_reset,
   input  wire logic                         i_uv_reset,
   input  wire logic                         i_dog_overflow,
   input  wire logic                         i_reset_pin_input_port,
   input  wire logic                         i_stop_instr,
   input  wire logic [smrc_pkg::NUM_IRQ-1:0] i_irq_request,
   input  wire logic [smrc_pkg::NUM_IRQ-1:0] i_irq_mask_flag,
   input  wire logic [smrc_pkg::NUM_IRQ-1:0] i_irq_wake_capable,
   input  wire logic                         i_irq_global_enable,
   input  wire logic                         i_crystal_sel,
   input  wire logic [smrc_pkg::OSC_SEL_W-1:0] i_osc_settle_select,
   input  wire logic                         i_tmr8_slow_clk_sel,
   input  wire logic                         i_dog_slow_clk_sel,
   input  wire logic                         i_slow_osc_unstoppable,
   input  wire logic                         i_slow_osc_sw_stop,
   input  wire logic [7:0]                   i_undervolt_cfg_wr,
   input  wire logic                         i_undervolt_cfg_we,
   output logic                              o_cpu_run,
   output logic                              o_cpu_reset,
   output logic                              o_load_reset_vector,
   output logic [15:0]                       o_vector_addr,
   output logic                              o_take_vector,
   output logic                              o_next_instr,
   output logic                              o_sys_osc_en,
   output logic                              o_slow_osc_en,
   output logic                              o_tmr16_en,
   output logic                              o_adc_en,
   output logic                              o_tmr8_en,
   output logic                              o_dog_en,
   output logic                              o_pins_hiz,
   output logic                              o_reset_low_output_pin,
   output logic                              o_port_latch_hold,
   output logic                              o_watchdog_cause_flag,
   output logic                              o_undervolt_cause_flag,
   output logic [7:0]                        o_undervolt_control,
   output logic                              o_in_stop
);
   import smrc_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] pin_s_q, por_s_q, uv_s_q;
   logic       pin_low, por_act, uv_act;

   // Two flops per asynchronous reset source
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_s_q <= 2'h3;
         por_s_q <= 2'h3;
         uv_s_q  <= 2'h0;
      end else begin
         pin_s_q <= {pin_s_q[0], i_reset_n_pin};
         por_s_q <= {por_s_q[0], i_por_reset};
         uv_s_q  <= {uv_s_q[0], i_uv_reset};
      end
   end
   assign pin_low = ~pin_s_q[1];
   assign por_act = por_s_q[1];
   assign uv_act  = uv_s_q[1];

   // ----------------------------------------------------------------
   // Pin low-time filter: pulses under 2 us are not taken
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] pin_cnt_q;
   logic             pin_rst_q;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_cnt_q <= '0;
         pin_rst_q <= 1'b0;
      end else if (!pin_low) begin
         pin_cnt_q <= '0;
         pin_rst_q <= 1'b0;
      end else if (pin_cnt_q >= CNT_W'(PIN_LOW_MIN_CYC - 1)) begin
         pin_rst_q <= 1'b1;
      end else begin
         pin_cnt_q <= pin_cnt_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Merged internal reset (any of four sources)
   // ----------------------------------------------------------------
   logic any_rst;
   logic dog_rst_q;
   // Pin acts as reset also when configured as input port
   assign any_rst = pin_rst_q | por_act | uv_act | dog_rst_q;

   // Watchdog reset is a one-cycle event that clears itself
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dog_rst_q <= 1'b0;
      end else begin
         dog_rst_q <= i_dog_overflow & ~dog_rst_q;
      end
   end

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   function automatic logic [CNT_W-1:0] osc_wait(
      input logic [OSC_SEL_W-1:0] sel);
      osc_wait = CNT_W'(OSC_SETTLE_BASE_CYC) << sel;
   endfunction : osc_wait

   smrc_state_type   state_q;
   logic [CNT_W-1:0] cnt_q;
   logic             wake_any, stop_cancel;
   logic             wake_ie_q;
   logic [NUM_IRQ-1:0] live_req;

   assign live_req    = i_irq_request & ~i_irq_mask_flag;
   assign stop_cancel = |live_req;
   assign wake_any    = |(live_req & i_irq_wake_capable);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q   <= SMRC_RESET;
         cnt_q     <= '0;
         wake_ie_q <= 1'b0;
      end else if (any_rst) begin
         // Merged sources assert and release synchronously here, not via i_sys_rst
         state_q <= SMRC_RESET;
         cnt_q   <= '0;
      end else begin
         unique case (state_q)
            SMRC_RESET: begin
               state_q <= SMRC_OPT_READ;
               cnt_q   <= '0;
            end
            SMRC_OPT_READ: begin
               if (cnt_q >= CNT_W'(OPT_READ_CYC - 1)) begin
                  cnt_q   <= '0;
                  state_q <= i_crystal_sel ? SMRC_RST_OSC : SMRC_RUN;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            SMRC_RST_OSC: begin
               if (cnt_q >= osc_wait(i_osc_settle_select) - 1'b1) begin
                  cnt_q   <= '0;
                  state_q <= SMRC_RUN;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            SMRC_RUN: begin
               // Stop only on the instruction, never on a pending request
               if (i_stop_instr && !stop_cancel) begin
                  state_q <= SMRC_STOP;
               end
            end
            SMRC_STOP: begin
               if (wake_any) begin
                  wake_ie_q <= i_irq_global_enable;
                  cnt_q     <= '0;
                  state_q   <= i_crystal_sel ? SMRC_WAKE_OSC
                                             : SMRC_WAKE_SETTLE;
               end
            end
            SMRC_WAKE_OSC: begin
               if (cnt_q >= osc_wait(i_osc_settle_select) - 1'b1) begin
                  cnt_q   <= '0;
                  state_q <= SMRC_WAKE_SETTLE;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            SMRC_WAKE_SETTLE: begin
               if (cnt_q >= CNT_W'(STOP_SETTLE_CYC - 1)) begin
                  cnt_q   <= '0;
                  state_q <= SMRC_RUN;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Reset cause flags and undervolt configuration
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_watchdog_cause_flag  <= 1'b0;
         o_undervolt_cause_flag <= 1'b0;
      end else if (pin_rst_q || por_act) begin
         o_watchdog_cause_flag  <= 1'b0;
         o_undervolt_cause_flag <= 1'b0;
      end else begin
         if (dog_rst_q) begin
            o_watchdog_cause_flag <= 1'b1;
         end
         if (uv_act) begin
            o_undervolt_cause_flag <= 1'b1;
         end
      end
   end

   // Undervolt reset alone leaves this register held
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_undervolt_control <= 8'h00;
      end else if (pin_rst_q || por_act || dog_rst_q) begin
         o_undervolt_control <= 8'h00;
      end else if (i_undervolt_cfg_we && !uv_act) begin
         o_undervolt_control <= i_undervolt_cfg_wr;
      end
   end

   // ----------------------------------------------------------------
   // Clock gating and outputs
   // ----------------------------------------------------------------
   logic in_rst_seq, in_stop, start_pulse;
   assign in_rst_seq = any_rst || state_q == SMRC_RESET
                    || state_q == SMRC_OPT_READ || state_q == SMRC_RST_OSC;
   assign in_stop    = state_q == SMRC_STOP;
   assign start_pulse = state_q == SMRC_RST_OSC
                     ? (cnt_q >= osc_wait(i_osc_settle_select) - 1'b1)
                     : (state_q == SMRC_OPT_READ && !i_crystal_sel
                        && cnt_q >= CNT_W'(OPT_READ_CYC - 1));

   // Registered enables; all outputs from flops
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cpu_run              <= 1'b0;
         o_cpu_reset            <= 1'b1;
         o_sys_osc_en           <= 1'b0;
         o_slow_osc_en          <= 1'b0;
         o_tmr16_en             <= 1'b0;
         o_adc_en               <= 1'b0;
         o_tmr8_en              <= 1'b0;
         o_dog_en               <= 1'b0;
         o_pins_hiz             <= 1'b1;
         o_reset_low_output_pin <= 1'b0;
         o_port_latch_hold      <= 1'b0;
         o_in_stop              <= 1'b0;
      end else begin
         o_cpu_run    <= state_q == SMRC_RUN && !any_rst;
         o_cpu_reset  <= in_rst_seq;
         // Both oscillators off while reset is asserted
         o_sys_osc_en <= !any_rst && state_q != SMRC_RESET
                         && !in_stop;
         o_slow_osc_en <= !any_rst && state_q != SMRC_RESET
                          && (i_slow_osc_unstoppable
                              || !i_slow_osc_sw_stop);
         o_tmr16_en   <= state_q == SMRC_RUN && !any_rst;
         o_adc_en     <= state_q == SMRC_RUN && !any_rst;
         o_tmr8_en    <= !in_rst_seq && (!in_stop
                         || (i_tmr8_slow_clk_sel
                             && (i_slow_osc_unstoppable
                                 || !i_slow_osc_sw_stop)));
         o_dog_en     <= !in_rst_seq && (in_stop
                         ? (i_dog_slow_clk_sel && i_slow_osc_unstoppable)
                         : (i_dog_slow_clk_sel
                            || !i_slow_osc_unstoppable));
         o_pins_hiz   <= in_rst_seq;
         o_reset_low_output_pin <= 1'b0;
         o_port_latch_hold <= in_stop || state_q == SMRC_WAKE_OSC
                              || state_q == SMRC_WAKE_SETTLE;
         o_in_stop    <= in_stop;
      end
   end

   // Vector load pulse and wake outcome pulses
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_load_reset_vector <= 1'b0;
         o_vector_addr       <= RESET_VEC_LO;
         o_take_vector       <= 1'b0;
         o_next_instr        <= 1'b0;
      end else begin
         o_load_reset_vector <= start_pulse && !any_rst;
         o_vector_addr       <= RESET_VEC_LO;
         o_take_vector       <= 1'b0;
         o_next_instr        <= 1'b0;
         if (!any_rst && state_q == SMRC_WAKE_SETTLE
             && cnt_q >= CNT_W'(STOP_SETTLE_CYC - 1)) begin
            o_take_vector <= wake_ie_q;
            o_next_instr  <= !wake_ie_q;
         end
      end
   end

   // A reset during stop exits through the reset path above
   logic unused_hi;
   assign unused_hi = ^RESET_VEC_HI ^ i_reset_pin_input_port;
endmodule : smrc_stop_reset

/* smrc_props.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Stop and reset sequencer checker
// ----------------------------------------------------------------
module smrc_props
   import smrc_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_reset_n_pin,
   input wire logic       i_por_reset,
   input wire logic       i_uv_reset,
   input wire logic       i_dog_overflow,
   input wire logic       i_stop_instr,
   input wire logic [7:0] i_irq_request,
   input wire logic [7:0] i_irq_mask_flag,
   input wire logic [7:0] i_irq_wake_capable,
   input wire logic       i_irq_global_enable,
   input wire logic       i_crystal_sel,
   input wire logic       i_tmr8_slow_clk_sel,
   input wire logic       i_dog_slow_clk_sel,
   input wire logic       i_slow_osc_unstoppable,
   input wire logic       o_cpu_run,
   input wire logic       o_take_vector,
   input wire logic       o_next_instr,
   input wire logic       o_sys_osc_en,
   input wire logic       o_slow_osc_en,
   input wire logic       o_tmr16_en,
   input wire logic       o_adc_en,
   input wire logic       o_tmr8_en,
   input wire logic       o_dog_en,
   input wire logic       o_port_latch_hold,
   input wire logic       o_in_stop
);
   localparam int SET_MIN = 4250;  // 17 us at 250 MHz
   localparam int SET_MAX = 16750; // 67 us at 250 MHz
   localparam int OPT_MIN = 69250; // 277 us at 250 MHz
   logic [19:0] halt_q;
   logic        from_stop_q;
   wire logic wake = |(i_irq_request & ~i_irq_mask_flag & i_irq_wake_capable);
   wire logic quiet = i_reset_n_pin & !i_por_reset & !i_uv_reset;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Halted cycles since stop exit or reset, and where the halt began
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         halt_q      <= '0;
         from_stop_q <= 1'b0;
      end else begin
         halt_q      <= (o_cpu_run || o_in_stop) ? '0 : halt_q + 20'h1;
         from_stop_q <= o_in_stop || (from_stop_q && quiet && !i_dog_overflow);
      end
   end
   property p_entry; $rose(o_in_stop) |-> $past(i_stop_instr, 2); endproperty
   a_entry: assert property (p_entry) else $error("bad entry");
   property p_cancel; o_cpu_run && i_stop_instr
      && |(i_irq_request & ~i_irq_mask_flag) |-> ##2 !o_in_stop; endproperty
   a_cancel: assert property (p_cancel) else $error("no cancel");
   property p_settle; $rose(o_cpu_run) && from_stop_q && !i_crystal_sel
      |-> halt_q >= SET_MIN && halt_q <= SET_MAX; endproperty
   a_settle: assert property (p_settle) else $error("bad settle");
   property p_gate; o_in_stop |-> o_port_latch_hold
      && !(o_cpu_run | o_sys_osc_en | o_tmr16_en | o_adc_en); endproperty
   a_gate: assert property (p_gate) else $error("bad gating");
   property p_tmr8; o_in_stop && $past(o_in_stop)
      && !$past(i_tmr8_slow_clk_sel) |-> !o_tmr8_en; endproperty
   a_tmr8: assert property (p_tmr8) else $error("timer runs");
   property p_dog; o_in_stop && $past(o_in_stop) && !($past(i_dog_slow_clk_sel)
      && $past(i_slow_osc_unstoppable)) |-> !o_dog_en; endproperty
   a_dog: assert property (p_dog) else $error("dog runs");
   // o_in_stop lags the state by one cycle, resets by two more
   property p_hold; o_in_stop && !$past(wake) && $past(quiet, 3)
      && $past(quiet, 4) && !$past(i_dog_overflow, 2) |=> o_in_stop;
   endproperty
   a_hold: assert property (p_hold) else $error("left stop");
   property p_pulse; o_take_vector || o_next_instr |-> o_take_vector
      != o_next_instr && o_take_vector == i_irq_global_enable; endproperty
   a_pulse: assert property (p_pulse) else $error("bad resume");
   property p_opt; $rose(o_cpu_run) && !from_stop_q |-> halt_q >= OPT_MIN;
   endproperty
   a_opt: assert property (p_opt) else $error("short read");
   property p_osc; i_uv_reset [*5] |-> !o_sys_osc_en && !o_slow_osc_en;
   endproperty
   a_osc: assert property (p_osc) else $error("osc on");
   c_stop: cover property ($rose(o_in_stop));
   c_vector: cover property (o_take_vector);
   c_next: cover property (o_next_instr);
endmodule : smrc_props
bind smrc_stop_reset smrc_props i_props (.*);

/* smrc_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Interrupt controller and external reset source
// ----------------------------------------------------------------
module smrc_partner
   import smrc_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_pin_go,
   input  wire logic [7:0] i_req,
   output logic            o_reset_n_pin,
   output logic [7:0]      o_irq_request
);
   logic [7:0] req_q = 8'h00;
   int         low_q = 0;
   // Request flags follow the sources one cycle later
   always @(posedge i_clk) req_q <= i_req;
   // Pin held low past the minimum width, then driven high
   always @(posedge i_clk) begin
      if (i_pin_go)
         low_q <= PIN_LOW_MIN_CYC + 100;
      else if (low_q > 0)
         low_q <= low_q - 1;
   end
   assign o_irq_request = req_q;
   assign o_reset_n_pin = (low_q == 0);
endmodule : smrc_partner

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import smrc_pkg::*;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_por_reset = 1'b0;
   logic i_uv_reset = 1'b0, i_dog_overflow = 1'b0, i_stop_instr = 1'b0;
   logic i_reset_pin_input_port = 1'b0, i_slow_osc_sw_stop = 1'b0;
   logic i_irq_global_enable = 1'b0, i_crystal_sel = 1'b0, pin_go = 1'b0;
   logic i_tmr8_slow_clk_sel = 1'b1, i_dog_slow_clk_sel = 1'b1;
   logic i_slow_osc_unstoppable = 1'b1, i_undervolt_cfg_we = 1'b0;
   logic [7:0] i_irq_mask_flag = 8'h02, i_irq_wake_capable = 8'h0f;
   logic [7:0] i_undervolt_cfg_wr = 8'h00, req = 8'h00, i_irq_request;
   logic [2:0] i_osc_settle_select = 3'h1;
   logic i_reset_n_pin, o_cpu_run, o_cpu_reset, o_load_reset_vector;
   logic o_take_vector, o_next_instr, o_sys_osc_en, o_slow_osc_en;
   logic o_tmr16_en, o_adc_en, o_tmr8_en, o_dog_en, o_pins_hiz, o_in_stop;
   logic o_reset_low_output_pin, o_port_latch_hold, o_watchdog_cause_flag;
   logic o_undervolt_cause_flag;
   logic [15:0] o_vector_addr;
   logic [7:0] o_undervolt_control;
   int errors = 0, checked = 0, n = 0, n1 = 0;
   wire logic [2:0] ev = {o_load_reset_vector, o_next_instr, o_take_vector};
   smrc_stop_reset i_dut (.*);
   smrc_partner i_far (
      .i_clk        (i_clk),
      .i_pin_go     (pin_go),
      .i_req        (req),
      .o_reset_n_pin(i_reset_n_pin),
      .o_irq_request(i_irq_request)
   );
   // Clock, 4 ns period
   always #2 i_clk = ~i_clk;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(negedge i_clk);
   endtask : cyc
   task automatic wait_ev(input int k, input int lim);
      n = 0;
      while (ev[k] !== 1'b1 && n < lim) begin
         @(negedge i_clk);
         n++;
      end
   endtask : wait_ev
   task automatic stop_enter();
      i_stop_instr = 1'b1;
      cyc(1);
      i_stop_instr = 1'b0;
      cyc(2);
   endtask : stop_enter
   task automatic summarize();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      @(negedge i_clk);
      check(o_pins_hiz, 1);
      check(o_reset_low_output_pin, 0);
      check({o_sys_osc_en, o_slow_osc_en}, 0);
      cyc(15);
      i_sys_rst = 1'b0;
      wait_ev(2, 300000);
      check(n >= 69250 && n <= 268750, 1);
      check(o_vector_addr, RESET_VEC_LO);
      cyc(2);
      check({o_cpu_run, o_cpu_reset, o_pins_hiz}, 4);
   endtask : t_reset
   task automatic t_cancel();
      req = 8'h04;
      cyc(2);
      stop_enter();
      check(o_in_stop, 0);
      req = 8'h00;
      cyc(2);
   endtask : t_cancel
   task automatic t_wake(input logic ge, input logic xtal);
      i_irq_global_enable = ge;
      i_crystal_sel = xtal;
      stop_enter();
      check(o_in_stop, 1);
      check({o_cpu_run, o_sys_osc_en, o_tmr16_en, o_adc_en}, 0);
      check(o_port_latch_hold, 1);
      check(o_tmr8_en, i_tmr8_slow_clk_sel);
      check(o_dog_en, i_dog_slow_clk_sel);
      req = 8'h02;
      cyc(10);
      check(o_in_stop, 1);
      req = 8'h22;
      cyc(10);
      check(o_in_stop, 1);
      req = 8'h26;
      wait_ev(ge ? 0 : 1, 40000);
      req = 8'h00;
      check(n < 40000, 1);
      cyc(2);
   endtask : t_wake
   task automatic t_resets();
      stop_enter();
      check(o_in_stop, 1);
      i_undervolt_cfg_wr = 8'h3c;
      i_undervolt_cfg_we = 1'b1;
      cyc(1);
      i_undervolt_cfg_we = 1'b0;
      i_uv_reset = 1'b1;
      cyc(8);
      check(o_cpu_run, 0);
      check(o_in_stop, 0);
      i_uv_reset = 1'b0;
      cyc(8);
      check(o_undervolt_control, 8'h3c);
      check({o_watchdog_cause_flag, o_undervolt_cause_flag}, 1);
      i_dog_overflow = 1'b1;
      cyc(1);
      i_dog_overflow = 1'b0;
      cyc(8);
      check({o_watchdog_cause_flag, o_undervolt_cause_flag}, 3);
      check(o_undervolt_control, 8'h00);
      pin_go = 1'b1;
      cyc(1);
      pin_go = 1'b0;
      cyc(700);
      // Only the minimum hold is timed here, to keep the run short
      wait_ev(2, 69250);
      check(n >= 69250, 1);
      check({o_cpu_reset, o_pins_hiz}, 3);
      check({o_watchdog_cause_flag, o_undervolt_cause_flag}, 0);
   endtask : t_resets
   // Main sequence
   initial begin
      t_reset();
      t_cancel();
      t_wake(1'b1, 1'b0);
      n1 = n;
      check(n >= 4250 && n <= 16750, 1);
      i_tmr8_slow_clk_sel = 1'b0;
      i_dog_slow_clk_sel = 1'b0;
      t_wake(1'b0, 1'b1);
      check(n - n1 >= 512 && n - n1 <= 514, 1);
      i_crystal_sel = 1'b0;
      t_resets();
      summarize();
   end
   // Hang guard, well past the expected run length
   initial begin
      #1100000;
      errors++;
      summarize();
   end
endmodule : tb
